// ### core/wdt_core.sv
// Watchdog timer core: APB register slave plus counter instance.
// Assumes APB on mclk; debug_halt is a pin from the debug logic.
`timescale 1ns/1ps
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic        mclk,       // System clock, 10 MHz.
  input  wire logic        reset,      // Synchronous reset, active high.
  input  wire logic        psel,       // APB select.
  input  wire logic        penable,    // APB access phase.
  input  wire logic        pwrite,     // APB direction.
  input  wire logic [11:0] paddr,      // APB byte address.
  input  wire logic [31:0] pwdata,     // APB write data.
  output logic [31:0]      prdata,     // APB read data.
  output logic             pready,     // APB ready.
  output logic             pslverr,    // APB error.
  input  wire logic        debug_halt, // Processor halted, asynchronous pin.
  output logic             wdt_irq,    // Interrupt request, active high.
  output logic             wdt_reset   // System reset request, active high.
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic        run;              // Counter and interrupt enabled.
  logic        reset_en;         // Reset output allowed.
  logic        debug_freeze_set; // Freeze during debug halt.
  logic        config_write_block; // Lock active.
  logic [31:0] reload_value;     // Reload register.
  logic        halt_s1;          // Synchroniser first stage.
  logic        halt_s2;          // Synchroniser second stage.
  logic [31:0] count;            // Counter value.
  logic        int_raw;          // Raw flag.
  logic        rst_req;          // Reset request from counter.
  logic [31:0] rd_mux;           // Read data before the flop.
  wdt_cmd_t    cmd;              // Strobes to the counter.

  // Every check below runs on mclk and rests while reset is high, except AST_RESET_STATE, which runs during reset.
  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // Bus decode: single access cycle, no wait states.
  // ----------------------------------------------------------------------
  wire logic acc     = psel && penable;
  wire logic wr      = acc && pwrite;
  wire logic mapped  = (paddr[1:0] == 2'h0) && (paddr <= WDT_OFS_DEBUG);
  // Configuration writes are swallowed while locked.
  wire logic cfg_ok  = wr && !config_write_block;
  wire logic wr_rel  = cfg_ok && (paddr == WDT_OFS_RELOAD);
  wire logic wr_ctl  = cfg_ok && (paddr == WDT_OFS_CTRL);
  wire logic wr_clr  = wr && (paddr == WDT_OFS_INTCLR);
  wire logic wr_lock = wr && (paddr == WDT_OFS_LOCK);
  wire logic wr_dbg  = cfg_ok && (paddr == WDT_OFS_DEBUG);
  wire logic masked_select = int_raw && run;

  // Zero wait states: every register is a flop or a small mux, so the
  // access phase always completes. A slower clock would not change this,
  // which keeps the host driver free of polling on ready.
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign cmd.load  = wr_rel;
  assign cmd.value = pwdata;
  assign cmd.clear = wr_clr;

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    case (paddr)
      WDT_OFS_RELOAD: rd_mux = reload_value;
      WDT_OFS_VALUE:  rd_mux = count;
      WDT_OFS_CTRL:   rd_mux = {30'h0, reset_en, run};
      WDT_OFS_RIS:    rd_mux = {31'h0, int_raw};
      WDT_OFS_MIS:    rd_mux = {31'h0, masked_select};
      WDT_OFS_LOCK:   rd_mux = {31'h0, config_write_block};
      WDT_OFS_DEBUG:  rd_mux = {31'h0, debug_freeze_set};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // Read data is registered at the setup cycle so it stands during access.
  // The cost is that a read sees the state one cycle before the access edge.
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers. Enable is sticky until system reset, as usual for
  // a watchdog: software cannot stop it, only configure it.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      run      <= 1'b0;
      reset_en <= 1'b0;
    end else if (wr_ctl) begin
      run      <= run | pwdata[WDT_CTRL_EN_BIT];
      reset_en <= pwdata[WDT_CTRL_RST_BIT];
    end
  end

  // Reload register. It keeps its value across timeouts so each reload
  // starts the same interval again.
  always_ff @(posedge mclk) begin
    if (reset) begin
      reload_value <= WDT_RELOAD_RST;
    end else if (wr_rel) begin
      reload_value <= pwdata;
    end
  end

  // Debug freeze enable.
  always_ff @(posedge mclk) begin
    if (reset) begin
      debug_freeze_set <= 1'b0;
    end else if (wr_dbg) begin
      debug_freeze_set <= pwdata[WDT_DBG_BIT];
    end
  end

  // Lock: the key unlocks, any other value locks. Stray writes therefore
  // fail safe: they can only close the configuration, never open it.
  always_ff @(posedge mclk) begin
    if (reset) begin
      config_write_block <= 1'b0;
    end else if (wr_lock) begin
      config_write_block <= (pwdata != WDT_UNLOCK_KEY);
    end
  end

  // ----------------------------------------------------------------------
  // Debug halt synchroniser.
  // ----------------------------------------------------------------------
  // The halt pin comes from another clock domain. Only the second stage
  // is read, so the freeze reacts two cycles late; a watchdog interval
  // is far longer than that, so the delay is harmless.
  always_ff @(posedge mclk) begin
    if (reset) begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end else begin
      halt_s1 <= debug_halt;
      halt_s2 <= halt_s1;
    end
  end

  wire logic freeze = debug_freeze_set && halt_s2;

  // ----------------------------------------------------------------------
  // Counter instance.
  // ----------------------------------------------------------------------
  wdt_counter u_counter (
    .mclk          (mclk),
    .reset         (reset),
    .run           (run),
    .freeze        (freeze),
    .reset_en      (reset_en),
    .cmd           (cmd),
    .reload_value  (reload_value),
    .count         (count),
    .int_raw       (int_raw),
    .sys_reset_req (rst_req)
  );

  // Outputs from flops: interrupt follows the masked flag.
  // The extra flop keeps decode glitches off the system pins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdt_irq   <= 1'b0;
      wdt_reset <= 1'b0;
    end else begin
      wdt_irq   <= masked_select;
      wdt_reset <= rst_req;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  // A zero reload shows first in the raw flag, then on the pin.
  sequence seq_flag_then_irq;
    int_raw ##1 wdt_irq;
  endsequence
  AST_LOCK_BLOCKS: assert property (@(posedge mclk) disable iff (reset)
    (wr && config_write_block && paddr == WDT_OFS_RELOAD) |=> $stable(reload_value))
    else $error("Reload changed while locked.");
  AST_UNLOCK: assert property (@(posedge mclk) disable iff (reset)
    (wr_lock && pwdata == WDT_UNLOCK_KEY) |=> !config_write_block)
    else $error("Unlock key did not unlock.");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    (wr_clr && count != WDT_ZERO && !wr_rel) |=> ##1 !wdt_irq)
    else $error("Interrupt did not clear.");
  AST_ENABLE: assert property (@(posedge mclk) disable iff (reset)
    (wr_ctl && pwdata[WDT_CTRL_EN_BIT]) |=> run)
    else $error("Enable did not start counter.");
  AST_ZERO_LOAD: assert property (@(posedge mclk) disable iff (reset)
    (wr_rel && run && pwdata == WDT_ZERO) |=> seq_flag_then_irq)
    else $error("Zero reload gave no interrupt.");

  // ----------------------------------------------------------------------
  // Output pins.
  // ----------------------------------------------------------------------
  // The interrupt pin is the masked flag one flop later.
  AST_IRQ_FOLLOWS: assert property (
    1'b1 |=> (wdt_irq == $past(masked_select)))
    else $error("Interrupt pin off its flag.");
  // The reset pin is the counter's request one flop later.
  AST_RESET_FOLLOWS: assert property (
    1'b1 |=> (wdt_reset == $past(rst_req)))
    else $error("Reset pin off its request.");
  // Once raised, the reset request waits for the system reset.
  // Dropping it early could let a hung system run on.
  AST_RESET_HOLDS: assert property (
    wdt_reset |=> wdt_reset)
    else $error("Reset request dropped.");
  // No interrupt reaches the pin before the watchdog is enabled.
  AST_IRQ_NEEDS_RUN: assert property (
    !run |=> !wdt_irq)
    else $error("Interrupt while disabled.");

  // ----------------------------------------------------------------------
  // Locking.
  // ----------------------------------------------------------------------
  // A locked control write changes neither enable nor reset enable.
  AST_LOCK_CTRL: assert property (
    (wr && config_write_block && paddr == WDT_OFS_CTRL) |=> $stable(run) && $stable(reset_en))
    else $error("Control changed while locked.");
  // A locked debug write leaves the freeze setting alone.
  AST_LOCK_DEBUG: assert property (
    (wr && config_write_block && paddr == WDT_OFS_DEBUG) |=> $stable(debug_freeze_set))
    else $error("Freeze changed while locked.");
  // Any value but the key closes the configuration.
  // This holds whether or not it was already closed.
  AST_LOCK_SET: assert property (
    (wr_lock && pwdata != WDT_UNLOCK_KEY) |=> config_write_block)
    else $error("Lock write did not lock.");
  // While open, a debug write lands in full.
  // This shows that unlocking really restores access.
  AST_UNLOCK_DEBUG: assert property (
    wr_dbg |=> (debug_freeze_set == $past(pwdata[WDT_DBG_BIT])))
    else $error("Open debug write lost.");

  // ----------------------------------------------------------------------
  // Counter.
  // ----------------------------------------------------------------------
  // An accepted reload write lands in the reload register.
  AST_RELOAD_WRITE: assert property (
    wr_rel |=> (reload_value == $past(pwdata)))
    else $error("Reload write lost.");
  // A reload write while running goes straight into the count.
  // Software uses this to restart the interval.
  AST_LOAD_NOW: assert property (
    (wr_rel && run) |=> (count == $past(pwdata)))
    else $error("Reload not loaded at once.");
  // Without freeze the count steps down even during a halt.
  // The halt pin is not looked at here on purpose.
  AST_STALL_OFF: assert property (
    (run && !debug_freeze_set && !wr_rel && count != WDT_ZERO)
    |=> (count == $past(count) - 32'h00000001))
    else $error("Count stalled without freeze.");
  // With freeze set but no halt, the count keeps stepping.
  // This is the resume half of the debug stall.
  AST_RESUME: assert property (
    (run && debug_freeze_set && !freeze && !wr_rel && count != WDT_ZERO)
    |=> (count == $past(count) - 32'h00000001))
    else $error("Count did not resume.");
  // A clear away from a timeout leaves the raw flag low.
  AST_CLEAR_RAW: assert property (
    (wr_clr && count != WDT_ZERO) |=> !int_raw)
    else $error("Raw flag not cleared.");
  // Software can never stop a running watchdog.
  AST_RUN_STICKY: assert property (
    run |=> run)
    else $error("Watchdog stopped.");

  // ----------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------
  // Setup phase of a read from one register.
  sequence seq_rd_setup(logic [11:0] ofs);
    psel && !penable && !pwrite && (paddr == ofs);
  endsequence
  // Read data is the mux output captured at setup.
  // Any register may be read at any time this way.
  AST_READ_CAPTURE: assert property (
    (psel && !penable && !pwrite) |=> (prdata == $past(rd_mux)))
    else $error("Read data not captured.");
  AST_RIS_READ: assert property (
    seq_rd_setup(WDT_OFS_RIS) |=> (prdata == {31'h00000000, $past(int_raw)}))
    else $error("Raw status read wrong.");
  // Masked status shows the flag only once enabled.
  AST_MIS_READ: assert property (
    seq_rd_setup(WDT_OFS_MIS) |=> (prdata == {31'h00000000, $past(int_raw && run)}))
    else $error("Masked status read wrong.");
  AST_LOCK_READ: assert property (
    seq_rd_setup(WDT_OFS_LOCK) |=> (prdata == {31'h00000000, $past(config_write_block)}))
    else $error("Lock state read wrong.");
  AST_RUN_READ: assert property (
    seq_rd_setup(WDT_OFS_CTRL) |=> (prdata[WDT_CTRL_EN_BIT] == $past(run)))
    else $error("Running state read wrong.");
  AST_VALUE_READ: assert property (
    seq_rd_setup(WDT_OFS_VALUE) |=> (prdata == $past(count)))
    else $error("Count read wrong.");

  // ----------------------------------------------------------------------
  // Reset state.
  // ----------------------------------------------------------------------
  // Checked while reset is high, so the default disable is overridden.
  // Every reset must leave the block stopped, open and quiet.
  AST_RESET_STATE: assert property (disable iff (1'b0)
    reset |=> (!run && !reset_en && !config_write_block && !debug_freeze_set
               && !wdt_irq && !wdt_reset))
    else $error("State after reset wrong.");

endmodule // wdt_core

// ### inc/wdt_pkg.sv
// Package for the watchdog timer core: register offsets, fields, reset values.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package wdt_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [11:0] WDT_OFS_RELOAD  = 12'h000;  // Reload value.
  localparam logic [11:0] WDT_OFS_VALUE   = 12'h004;  // Current count, read only.
  localparam logic [11:0] WDT_OFS_CTRL    = 12'h008;  // Enable, reset enable.
  localparam logic [11:0] WDT_OFS_INTCLR  = 12'h00C;  // Write any value to clear.
  localparam logic [11:0] WDT_OFS_RIS     = 12'h010;  // Raw status.
  localparam logic [11:0] WDT_OFS_MIS     = 12'h014;  // Masked status.
  localparam logic [11:0] WDT_OFS_LOCK    = 12'h018;  // Lock key / lock state.
  localparam logic [11:0] WDT_OFS_DEBUG   = 12'h01C;  // Debug freeze enable.

  // ----------------------------------------------------------------------
  // Field positions and values.
  // ----------------------------------------------------------------------
  localparam int          WDT_CTRL_EN_BIT   = 0;          // Counter and interrupt on.
  localparam int          WDT_CTRL_RST_BIT  = 1;          // Reset output allowed.
  localparam int          WDT_DBG_BIT       = 0;          // Debug freeze set.
  localparam logic [31:0] WDT_UNLOCK_KEY    = 32'h1ACCE551; // Key that unlocks.
  localparam logic [31:0] WDT_RELOAD_RST    = 32'hFFFFFFFF; // Reload after reset.
  localparam logic [31:0] WDT_ZERO          = 32'h00000000; // Terminal count.

  // Configuration write strobes carried to the counter.
  typedef struct packed {
    logic        load;    // Reload register written.
    logic [31:0] value;   // New reload value.
    logic        clear;   // Interrupt clear.
  } wdt_cmd_t;

endpackage : wdt_pkg

// ### core/wdt_counter.sv
// Down counter with timeout detection for the watchdog timer core.
// Assumes commands arrive on mclk from the register block.
`timescale 1ns/1ps
module wdt_counter
  import wdt_pkg::*;
(
  input  wire logic        mclk,         // System clock.
  input  wire logic        reset,        // Synchronous reset, active high.
  input  wire logic        run,          // Watchdog enabled.
  input  wire logic        freeze,       // Hold the count this cycle.
  input  wire logic        reset_en,     // Second timeout may reset.
  input  wire wdt_cmd_t    cmd,          // Load and clear strobes.
  input  wire logic [31:0] reload_value, // Reload register.
  output logic [31:0]      count,        // Present count.
  output logic             int_raw,      // Sticky timeout flag.
  output logic             sys_reset_req // Reset request, held till reset.
);

  // ----------------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------------
  wire logic at_zero  = (count == WDT_ZERO);               // Terminal count.
  wire logic step     = run && !freeze;
  wire logic timeout  = step && at_zero;                   // Count hit zero.
  // Writing zero while running raises the flag at once.
  wire logic zero_ld  = run && cmd.load && (cmd.value == WDT_ZERO);

  // ----------------------------------------------------------------------
  // Counter: load wins over a step, timeout reloads.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= WDT_RELOAD_RST;
    end else if (run && cmd.load) begin
      count <= cmd.value;
    end else if (timeout) begin
      count <= reload_value;
    end else if (step) begin
      count <= count - 32'h00000001;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flag: a timeout in the clear cycle wins over the clear.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_raw <= 1'b0;
    end else if (timeout || zero_ld) begin
      int_raw <= 1'b1;
    end else if (cmd.clear) begin
      int_raw <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Reset request stays until the system reset takes the block down.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_reset_req <= 1'b0;
    end else if (timeout && int_raw && reset_en) begin
      sys_reset_req <= 1'b1;
    end
  end

  AST_SECOND_TIMEOUT: assert property (@(posedge mclk) disable iff (reset)
    (timeout && int_raw && reset_en) |=> sys_reset_req)
    else $error("Second timeout did not raise reset.");
  AST_NO_RESET_DISABLED: assert property (@(posedge mclk) disable iff (reset)
    (!sys_reset_req && !reset_en) |=> !sys_reset_req)
    else $error("Reset raised while disabled.");
  AST_FREEZE_HOLD: assert property (@(posedge mclk) disable iff (reset)
    (freeze && !cmd.load) |=> $stable(count))
    else $error("Count moved while frozen.");
  AST_RELOAD_ON_ZERO: assert property (@(posedge mclk) disable iff (reset)
    (timeout && !cmd.load) |=> (count == $past(reload_value)) && int_raw)
    else $error("Timeout did not reload and flag.");

endmodule // wdt_counter

// ### test/wdt_host_model.sv
// Model of the processor side of the watchdog: debug halt pin and reset sink.
// Assumes the bench asks for halts in step with mclk; the pin itself is async.
`timescale 1ns/1ps
module wdt_host_model (
  input  wire logic mclk,       // System clock.
  input  wire logic reset,      // Synchronous reset, active high.
  input  wire logic halt_req,   // Bench asks the processor to halt.
  input  wire logic wdt_reset,  // Reset request from the core.
  output logic      debug_halt, // Halt pin towards the core.
  output logic      rst_seen    // A reset request reached the system.
);
  // The pin moves on the falling edge, so the core's synchroniser sees an
  // edge that is unrelated to its own sampling edge.
  initial debug_halt = 1'b0;
  always @(negedge mclk) debug_halt <= halt_req;

  // The system reset logic remembers any request until the next reset.
  initial rst_seen = 1'b0;
  always @(posedge mclk) begin
    if (reset) begin
      rst_seen <= 1'b0;
    end else if (wdt_reset) begin
      rst_seen <= 1'b1;
    end
  end
endmodule // wdt_host_model

// ### test/test_watchdog_timer_core.sv
// Self-checking bench for the watchdog core: APB driver, read monitor, timing.
// Assumes the zero-wait APB slave and register map of wdt_core.
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t %s", $time, m); end end
module test_watchdog_timer_core import wdt_pkg::*;;
  // --------------------------------------------------------------
  // Signals and expected-result notes.
  // --------------------------------------------------------------
  typedef struct { logic [31:0] d; logic err; bit rd; } wdt_exp_t;
  logic        mclk, reset, psel, penable, pwrite, halt_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, debug_halt, wdt_irq, wdt_reset, rst_seen;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wdt_exp_t    q[$];     // Notes from the driver, oldest first.
  wdt_exp_t    e;        // Note taken by the monitor.
  // Configuration places first, so the locked-write loop can reuse them.
  logic [11:0] ofs [7] = '{WDT_OFS_RELOAD, WDT_OFS_CTRL, WDT_OFS_DEBUG,
                           WDT_OFS_LOCK, WDT_OFS_VALUE, WDT_OFS_RIS, WDT_OFS_MIS};
  logic [31:0] rv [7] = '{WDT_RELOAD_RST, WDT_ZERO, WDT_ZERO, WDT_ZERO,
                          WDT_RELOAD_RST, WDT_ZERO, WDT_ZERO};

  wdt_core DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
    .wdt_irq(wdt_irq), .wdt_reset(wdt_reset));
  wdt_host_model host (.mclk(mclk), .reset(reset), .halt_req(halt_req),
    .wdt_reset(wdt_reset), .debug_halt(debug_halt), .rst_seen(rst_seen));

  // 10 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // A hang costs a mismatch; the whole run needs well under 5000 cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Monitor: every completed transfer consumes the oldest note.
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      e = q.pop_front();
      if (e.rd) `CHK(prdata, e.d, "read data")
      `CHK(pslverr, e.err, "error response")
    end
  end

  // --------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------
  // One APB transfer; for a read, d is the expected data. An idle cycle
  // follows so that psel is never assigned twice in one time step.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic err = 1'b0);
    int k;
    k = 0;
    q.push_back('{d, err, !wr && !err});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Reset for twelve cycles; pending notes belong to the old run.
  task do_reset();
    reset <= 1'b1;
    halt_req <= 1'b0;
    q.delete();
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask

  // The chosen output (1 = reset, 0 = interrupt) must rise in [lo, hi).
  task wait_sig(input bit which, input int lo, input int hi);
    int i;
    for (i = 0; i < hi; i++) begin
      @(posedge mclk);
      if ((which ? wdt_reset : wdt_irq) === 1'b1) break;
    end
    `CHK((i >= lo) && (i < hi), 1'b1, "event timing")
  endtask

  // The chosen output must stay low for n cycles.
  task stay_low(input bit which, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      seen |= (which ? wdt_reset : wdt_irq);
    end
    `CHK(seen, 1'b0, "output rose")
  endtask

  task wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset = 1'b1;
    halt_req = 1'b0;
    void'($urandom(4404));
    r = 32'h28 + ($urandom % 40);
    do_reset();
    foreach (ofs[i]) apb(0, ofs[i], rv[i]);
    `CHK({wdt_irq, wdt_reset}, 2'b00, "outputs after reset")
    // Locked: configuration writes must vanish; top nibble 0 avoids the key.
    apb(1, WDT_OFS_LOCK, $urandom & 32'h0FFFFFFF);
    apb(0, WDT_OFS_LOCK, 32'h1);
    for (int i = 0; i < 3; i++) apb(1, ofs[i], 32'h3);
    for (int i = 0; i < 3; i++) apb(0, ofs[i], rv[i]);
    apb(1, WDT_OFS_LOCK, WDT_UNLOCK_KEY);
    apb(0, WDT_OFS_LOCK, 32'h0);
    apb(1, 12'h020, 32'h0, 1'b1);
    // Enable without reset: timeout, status, clear, next timeout.
    apb(1, WDT_OFS_CTRL, 32'h1);
    apb(0, WDT_OFS_CTRL, 32'h1);
    apb(1, WDT_OFS_RELOAD, r);
    wait_sig(0, r - 3, r + 8);
    apb(0, WDT_OFS_RIS, 32'h1);
    apb(0, WDT_OFS_MIS, 32'h1);
    apb(0, WDT_OFS_RELOAD, r);
    stay_low(1, 2 * r);
    // Reload first so no timeout can collide with the clear.
    apb(1, WDT_OFS_RELOAD, r);
    apb(1, WDT_OFS_INTCLR, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(wdt_irq, 1'b0, "irq after clear")
    apb(0, WDT_OFS_RIS, 32'h0);
    wait_sig(0, r - 20, r + 8);
    // A zero reload raises the interrupt at once.
    do_reset();
    apb(1, WDT_OFS_CTRL, 32'h1);
    apb(1, WDT_OFS_RELOAD, 32'h0);
    wait_sig(0, 0, 6);
    // Second uncleared timeout with reset enabled.
    do_reset();
    apb(1, WDT_OFS_CTRL, 32'h3);
    apb(1, WDT_OFS_RELOAD, r);
    wait_sig(1, 2 * r - 4, 2 * r + 12);
    @(posedge mclk);
    `CHK(rst_seen, 1'b1, "system saw reset")
    // Debug freeze holds the count while halted.
    do_reset();
    `CHK(wdt_reset, 1'b0, "reset request after reset")
    apb(1, WDT_OFS_DEBUG, 32'h1);
    apb(1, WDT_OFS_CTRL, 32'h1);
    apb(1, WDT_OFS_RELOAD, r);
    halt_req <= 1'b1;
    stay_low(0, 3 * r);
    halt_req <= 1'b0;
    wait_sig(0, r - 10, r + 10);
    // Without freeze a halt changes nothing.
    do_reset();
    apb(1, WDT_OFS_CTRL, 32'h1);
    halt_req <= 1'b1;
    apb(1, WDT_OFS_RELOAD, r);
    wait_sig(0, r - 3, r + 8);
    halt_req <= 1'b0;
    wrap_up();
  end
endmodule // test_watchdog_timer_core
